// ---- verilog/esu_cfg.svh ----
`ifndef ESU_CFG_SVH
`define ESU_CFG_SVH

// ==================================================================
// register map
`define ESU_AW 8
`define ESU_OFF_CTRL 8'h00
`define ESU_OFF_STAT 8'h04
`define ESU_OFF_DREC 8'h08
`define ESU_OFF_RADDR 8'h0c
`define ESU_OFF_TSYN 8'h10

// ==================================================================
// fields and reset values
`define ESU_CTRL_IMPL_EN 0
`define ESU_CTRL_PRIO 1
`define ESU_CTRL_W 2
`define ESU_CTRL_RST 2'h2
`define ESU_DREC_VALID 31
`define ESU_TSYN_IESB 24
`define ESU_STAT_SYNC 0
`define ESU_STAT_UNSYNC 1
`define ESU_STAT_BUSY 2
`define ESU_SYN_W 24
`define ESU_SYN_ST_LSB 21
`define ESU_DET_W 21
`define ESU_FEAT_IMPL 1'h1
`define ESU_HTRANS_NONSEQ 2'h2

`endif

// ---- verilog/esu_pkg.sv ----
`default_nettype none
`include "esu_cfg.svh"

package esu_pkg;

  // ordered by severity, impdef kept apart by the merge
  typedef enum logic [2:0] {
    ESU_CORR, ESU_RESTART, ESU_RECOV, ESU_UNREC, ESU_UNCONT, ESU_IMPDEF
  } esu_state_t;

  typedef enum logic [1:0] {EV_BARRIER, EV_ENTRY, EV_RETURN} esu_ev_t;

  typedef enum logic [1:0] {S_IDLE, S_DRAIN, S_RESOLVE, S_CLEAR} esu_fsm_t;

  typedef logic [`ESU_SYN_W-1:0] esu_syn_t;

  typedef struct packed {
    esu_fsm_t fsm;
    logic [`ESU_CTRL_W-1:0] ctrl;
    esu_ev_t kind;
    logic [31:0] evAddr;
    logic syncPend;
    esu_syn_t syncSyn;
    logic unsyncPend;
    esu_syn_t unsyncSyn;
    logic drecValid;
    esu_syn_t drecSyn;
    logic take;
    logic [31:0] retAddr;
    esu_syn_t takeSyn;
    logic iesb;
    logic pendOut;
    logic done;
  } esu_top_st_t;

  // combined syndrome of several pending conditions
  function automatic esu_syn_t esu_merge(input esu_syn_t a,
                                         input esu_syn_t b);
    logic [2:0] sa;
    logic [2:0] sb;
    esu_syn_t r;
    sa = a[`ESU_SYN_W-1:`ESU_SYN_ST_LSB];
    sb = b[`ESU_SYN_W-1:`ESU_SYN_ST_LSB];
    r = a | b;
    if (sa == ESU_IMPDEF || sb == ESU_IMPDEF) begin
      r[`ESU_SYN_W-1:`ESU_SYN_ST_LSB] = ESU_IMPDEF;
    end else begin
      r[`ESU_SYN_W-1:`ESU_SYN_ST_LSB] = (sa > sb) ? sa : sb;
    end
    return r;
  endfunction

endpackage

`default_nettype wire

// ---- verilog/esu_reg_if.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "esu_cfg.svh"

interface esu_reg_if;
  logic [`ESU_AW-1:0] addr;
  logic wrEn;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport slave(output addr, output wrEn, output wdata, input rdata);
  modport regs(input addr, input wrEn, input wdata, output rdata);
endinterface

`default_nettype wire

// ---- verilog/esu_err_classify.sv ----
`timescale 1ns/1ps
`default_nettype none

module esu_err_classify (
  input wire esu_pkg::esu_state_t rawState,
  input wire logic syncHint,
  input wire logic silent,
  input wire logic levelSrc,
  input wire logic rasIrq,
  input wire logic notConsumed,
  output var esu_pkg::esu_state_t state,
  output logic synced,
  output logic pend
);
  always_comb begin
    state = rawState;
    // silent propagation is uncontainable unless impdef-reported
    if (silent && rawState != esu_pkg::ESU_IMPDEF) begin
      state = esu_pkg::ESU_UNCONT;
    end
    synced = syncHint;
    if (state == esu_pkg::ESU_UNREC || state == esu_pkg::ESU_RECOV ||
        state == esu_pkg::ESU_RESTART) begin
      synced = 1'b1;
    end
    if (levelSrc || rasIrq) begin
      synced = 1'b0;
    end
    // not consumed: recoverable, never raises a system error here
    pend = !notConsumed && !rasIrq;
  end
endmodule

`default_nettype wire

// ---- verilog/esu_ahb_slave.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "esu_cfg.svh"

module esu_ahb_slave (
  input wire logic clock,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  esu_reg_if.slave rb
);
  typedef struct packed {
    logic pend;
    logic wr;
    logic [`ESU_AW-1:0] addr;
    logic rdy;
    logic [31:0] rdata;
  } esu_ahb_st_t;

  esu_ahb_st_t q;
  esu_ahb_st_t d;

  // one wait state so that read data comes from a flop
  always_comb begin
    d = q;
    d.rdy = 1'b1;
    if (q.pend) begin
      d.pend = 1'b0;
      d.rdata = q.wr ? 32'h0000_0000 : rb.rdata;
    end else if (hsel && hready && htrans == `ESU_HTRANS_NONSEQ) begin
      d.pend = 1'b1;
      d.wr = hwrite;
      d.addr = haddr[`ESU_AW-1:0];
      d.rdy = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      q <= '0;
      q.rdy <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // hsize unused: only whole-word transfers are defined
  assign rb.addr = q.addr;
  assign rb.wrEn = q.pend && q.wr;
  assign rb.wdata = hwdata;
  assign hreadyout = q.rdy;
  assign hresp = 1'b0;
  assign hrdata = q.rdata;
endmodule

`default_nettype wire

// ---- verilog/esu_error_sync_event_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "esu_cfg.svh"

// Overview of operation
// - masked barrier without deferral: earlier instructions all done
// - barrier or return event: error taken after that instruction
// - entry event: taken at handler start with syndrome bit zero
// - unmasked or synchronous: earlier error never taken after event
// - masked, non-barrier event: synchronized error stays pending
// - unrecoverable, recoverable, restartable errors are always synced; code leaves them unsynced if level-sourced or irq-raised
// - silently propagated errors reported uncontainable unless impdef
// - level-sensitive impdef system errors are never synchronized
// - another exception may win; system error then stays pending
// - system error preferably prioritised over other exceptions
// - masked barrier: record syndrome, set valid, then clear pending
// - record uses the same syndrome criteria as a taken error
// - error taken at barrier returns to the barrier address
// - masked barrier keeps unsynchronized errors pending, no record
// - system-level recovery and fault interrupts are not synchronized
// - one event synchronizes every pending synchronizable error
// - event first pends earlier errors, takes them if unmasked
// - event is no speculation barrier; later errors may arrive
// - deferred, corrected, speculative-read errors are not consumed
// - barrier always raises an event; entry, return when enabled; code drops all three unless the sequence is idle
// - implicit events leave the deferred record unchanged
module esu_error_sync_event_unit (
  input wire logic clock,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic errorBarrierInstr,
  input wire logic exceptionEntry,
  input wire logic exceptionReturn,
  input wire logic [31:0] eventAddr,
  input wire logic [31:0] curPc,
  input wire logic serrMasked,
  input wire logic otherExcReq,
  input wire logic errOutstanding,
  input wire logic errValid,
  input wire logic [2:0] errState,
  input wire logic [`ESU_DET_W-1:0] errDetail,
  input wire logic errSyncHint,
  input wire logic errSilent,
  input wire logic errLevelSrc,
  input wire logic errRasIrq,
  input wire logic errNotConsumed,
  output logic serrTake,
  output logic [31:0] serrRetAddr,
  output logic [`ESU_SYN_W-1:0] serrSyndrome,
  output logic implicitSyncSyndromeBit,
  output logic serrPending,
  output logic syncEventDone,
  output logic syncBusy
);

  // ==================================================================
  // register bus
  esu_reg_if rb();

  esu_ahb_slave u_ahb (
    .clock(clock),
    .nrst(nrst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .rb(rb)
  );

  // ==================================================================
  // error classification
  esu_pkg::esu_state_t clsState;
  logic clsSynced;
  logic clsPend;

  esu_err_classify u_cls (
    .rawState(esu_pkg::esu_state_t'(errState)),
    .syncHint(errSyncHint),
    .silent(errSilent),
    .levelSrc(errLevelSrc),
    .rasIrq(errRasIrq),
    .notConsumed(errNotConsumed),
    .state(clsState),
    .synced(clsSynced),
    .pend(clsPend)
  );

  // ==================================================================
  // state
  esu_pkg::esu_top_st_t q;
  esu_pkg::esu_top_st_t d;

  esu_pkg::esu_syn_t newSyn;
  esu_pkg::esu_syn_t allSyn;
  logic newSync;
  logic newUnsync;
  logic evImplicit;
  logic canTake;
  logic anyPend;

  assign newSyn = {clsState, errDetail};
  assign newSync = errValid && clsPend && clsSynced;
  assign newUnsync = errValid && clsPend && !clsSynced;
  // implicit events only with the feature built in and enabled
  assign evImplicit = `ESU_FEAT_IMPL && q.ctrl[`ESU_CTRL_IMPL_EN] &&
                      (exceptionEntry || exceptionReturn);
  // priority bit set: system error beats a competing exception
  assign canTake = !otherExcReq || q.ctrl[`ESU_CTRL_PRIO];
  assign anyPend = q.syncPend || q.unsyncPend;

  // all pending conditions go out as one exception
  always_comb begin
    if (q.syncPend && q.unsyncPend) begin
      allSyn = esu_pkg::esu_merge(q.syncSyn, q.unsyncSyn);
    end else if (q.syncPend) begin
      allSyn = q.syncSyn;
    end else begin
      allSyn = q.unsyncSyn;
    end
  end

  // ==================================================================
  // next state: software writes, then the sequence, then arrivals,
  // so hardware sets always win over clears in the same cycle
  always_comb begin
    d = q;
    d.take = 1'b0;
    d.done = 1'b0;

    if (rb.wrEn && rb.addr == `ESU_OFF_CTRL) begin
      d.ctrl = rb.wdata[`ESU_CTRL_W-1:0];
    end
    if (rb.wrEn && rb.addr == `ESU_OFF_DREC) begin
      d.drecValid = rb.wdata[`ESU_DREC_VALID];
      d.drecSyn = rb.wdata[`ESU_SYN_W-1:0];
    end

    unique case (q.fsm)
      esu_pkg::S_IDLE: begin
        if (errorBarrierInstr) begin
          d.kind = esu_pkg::EV_BARRIER;
          d.evAddr = eventAddr;
          d.fsm = esu_pkg::S_DRAIN;
        end else if (evImplicit) begin
          d.kind = exceptionEntry ? esu_pkg::EV_ENTRY : esu_pkg::EV_RETURN;
          d.evAddr = eventAddr;
          d.fsm = esu_pkg::S_DRAIN;
        end else if (anyPend && !serrMasked && canTake) begin
          d.take = 1'b1;
          d.retAddr = curPc;
          d.takeSyn = allSyn;
          d.iesb = 1'b0;
          d.syncPend = 1'b0;
          d.unsyncPend = 1'b0;
        end
      end
      esu_pkg::S_DRAIN: begin
        // earlier erring accesses must report before deciding
        if (!errOutstanding) begin
          d.fsm = esu_pkg::S_RESOLVE;
        end
      end
      esu_pkg::S_RESOLVE: begin
        if (q.syncPend && !serrMasked) begin
          if (canTake) begin
            d.take = 1'b1;
            // taken after the barrier/return, or at the handler start
            d.retAddr = q.evAddr;
            d.takeSyn = allSyn;
            d.iesb = 1'b0;
            d.syncPend = 1'b0;
            d.unsyncPend = 1'b0;
          end
          // otherwise the other exception wins and ours stays pending
          d.fsm = esu_pkg::S_IDLE;
          d.done = 1'b1;
        end else if (q.syncPend && q.kind == esu_pkg::EV_BARRIER) begin
          // record and flag now, clear pending in the next cycle
          d.drecSyn = q.syncSyn;
          d.drecValid = 1'b1;
          d.fsm = esu_pkg::S_CLEAR;
        end else begin
          // masked implicit event or no synchronized error pending: left pending, record untouched
          d.fsm = esu_pkg::S_IDLE;
          d.done = 1'b1;
        end
      end
      esu_pkg::S_CLEAR: begin
        d.syncPend = 1'b0;
        d.fsm = esu_pkg::S_IDLE;
        d.done = 1'b1;
      end
    endcase

    // arrivals are accepted in every state, speculative ones too
    if (newSync) begin
      d.syncSyn = d.syncPend ? esu_pkg::esu_merge(d.syncSyn, newSyn)
                             : newSyn;
      d.syncPend = 1'b1;
    end
    if (newUnsync) begin
      d.unsyncSyn = d.unsyncPend ? esu_pkg::esu_merge(d.unsyncSyn, newSyn)
                                 : newSyn;
      d.unsyncPend = 1'b1;
    end
    d.pendOut = d.syncPend || d.unsyncPend;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      q <= '0;
      q.ctrl <= `ESU_CTRL_RST;
    end else begin
      q <= d;
    end
  end

  // ==================================================================
  // register read mux
  always_comb begin
    rb.rdata = 32'h0000_0000;
    unique case (rb.addr)
      `ESU_OFF_CTRL: rb.rdata[`ESU_CTRL_W-1:0] = q.ctrl;
      `ESU_OFF_STAT: begin
        rb.rdata[`ESU_STAT_SYNC] = q.syncPend;
        rb.rdata[`ESU_STAT_UNSYNC] = q.unsyncPend;
        rb.rdata[`ESU_STAT_BUSY] = q.fsm != esu_pkg::S_IDLE;
      end
      `ESU_OFF_DREC: begin
        rb.rdata[`ESU_DREC_VALID] = q.drecValid;
        rb.rdata[`ESU_SYN_W-1:0] = q.drecSyn;
      end
      `ESU_OFF_RADDR: rb.rdata = q.retAddr;
      `ESU_OFF_TSYN: begin
        rb.rdata[`ESU_TSYN_IESB] = q.iesb;
        rb.rdata[`ESU_SYN_W-1:0] = q.takeSyn;
      end
      default: rb.rdata = 32'h0000_0000;
    endcase
  end

  // ==================================================================
  // outputs
  assign serrTake = q.take;
  assign serrRetAddr = q.retAddr;
  assign serrSyndrome = q.takeSyn;
  assign implicitSyncSyndromeBit = q.iesb;
  assign serrPending = q.pendOut;
  assign syncEventDone = q.done;
  assign syncBusy = q.fsm != esu_pkg::S_IDLE;

  // ==================================================================
  // checks
  AST_TAKE_UNMASKED: assert property (
    @(posedge clock) disable iff (!nrst)
    serrTake |-> !$past(serrMasked))
    else $error("system error taken while masked");

  // an arrival in the clearing cycle is kept, so it may re-pend
  AST_DEFER_SEQ: assert property (
    @(posedge clock) disable iff (!nrst)
    (q.fsm == esu_pkg::S_RESOLVE && q.syncPend && serrMasked &&
     q.kind == esu_pkg::EV_BARRIER)
    |=> q.drecValid && q.syncPend ##1 (!q.syncPend || $past(newSync)))
    else $error("deferral order broken");

  AST_IMPLICIT_NO_RECORD: assert property (
    @(posedge clock) disable iff (!nrst)
    (q.fsm == esu_pkg::S_RESOLVE && q.kind != esu_pkg::EV_BARRIER &&
     !rb.wrEn) |=> $stable(q.drecValid) && $stable(q.drecSyn))
    else $error("implicit event touched deferred record");

  AST_UNSYNC_STAYS: assert property (
    @(posedge clock) disable iff (!nrst)
    (q.fsm == esu_pkg::S_RESOLVE && q.unsyncPend && serrMasked)
    |=> q.unsyncPend)
    else $error("unsynchronized error dropped by barrier");

  // pending must still stand in the cycle the event completes
  AST_MASKED_KEEP: assert property (
    @(posedge clock) disable iff (!nrst)
    (q.fsm == esu_pkg::S_RESOLVE && q.syncPend && serrMasked &&
     q.kind != esu_pkg::EV_BARRIER) |=> q.syncPend && syncEventDone)
    else $error("masked implicit event cleared pending error");

  AST_BARRIER_RETADDR: assert property (
    @(posedge clock) disable iff (!nrst)
    (q.fsm == esu_pkg::S_RESOLVE && q.kind == esu_pkg::EV_BARRIER &&
     q.syncPend && !serrMasked && canTake)
    |=> serrTake && serrRetAddr == $past(q.evAddr))
    else $error("barrier return address wrong");

  AST_RECORD_HOLDS: assert property (
    @(posedge clock) disable iff (!nrst)
    (q.drecValid && !(rb.wrEn && rb.addr == `ESU_OFF_DREC))
    |=> q.drecValid)
    else $error("deferred valid flag lost");

  AST_IESB_ZERO: assert property (
    @(posedge clock) disable iff (!nrst)
    serrTake |-> !implicitSyncSyndromeBit)
    else $error("syndrome bit set at handler start");

  AST_DRAIN_FIRST: assert property (
    @(posedge clock) disable iff (!nrst)
    (q.fsm == esu_pkg::S_DRAIN && errOutstanding)
    |=> q.fsm == esu_pkg::S_DRAIN)
    else $error("resolved before earlier errors reported");

  AST_LEVEL_NOSYNC: assert property (
    @(posedge clock) disable iff (!nrst)
    errValid && errLevelSrc |=> !$rose(q.syncPend) || $past(newSync))
    else $error("level-sensitive error synchronized");

  AST_SILENT_UC: assert property (
    @(posedge clock) disable iff (!nrst)
    errValid && errSilent && errState != esu_pkg::ESU_IMPDEF
    |-> clsState == esu_pkg::ESU_UNCONT)
    else $error("silent error not uncontainable");

  AST_STATE_SYNCED: assert property (
    @(posedge clock) disable iff (!nrst)
    errValid && !errLevelSrc && !errRasIrq &&
    (clsState == esu_pkg::ESU_UNREC || clsState == esu_pkg::ESU_RECOV)
    |-> clsSynced)
    else $error("recoverable-class error not synchronized");

endmodule

`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "esu_cfg.svh"

module tb_top;
  // ==================================================================
  // stimulus and observation
  logic clock, nrst, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, eventAddr, curPc, serrRetAddr;
  logic [1:0] htrans;
  logic [2:0] hsize, errState;
  logic errorBarrierInstr, exceptionEntry, exceptionReturn;
  logic serrMasked, otherExcReq, errOutstanding, errValid, errSyncHint;
  logic errSilent, errLevelSrc, errRasIrq, errNotConsumed;
  logic [`ESU_DET_W-1:0] errDetail;
  logic [`ESU_SYN_W-1:0] serrSyndrome;
  logic serrTake, implicitSyncSyndromeBit, serrPending;
  logic syncEventDone, syncBusy, took, done;
  int errCount, samplesChecked;
  localparam logic [7:0] CT = `ESU_OFF_CTRL;
  localparam logic [7:0] ST = `ESU_OFF_STAT;
  localparam logic [7:0] DR = `ESU_OFF_DREC;
  localparam logic [7:0] RA = `ESU_OFF_RADDR;
  localparam logic [7:0] TS = `ESU_OFF_TSYN;
  localparam logic [31:0] PC = 32'h0000_1230;

  assign hready = hreadyout;

  esu_error_sync_event_unit i_dut (
    .clock, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .errorBarrierInstr,
    .exceptionEntry, .exceptionReturn, .eventAddr, .curPc, .serrMasked,
    .otherExcReq, .errOutstanding, .errValid, .errState, .errDetail,
    .errSyncHint, .errSilent, .errLevelSrc, .errRasIrq, .errNotConsumed,
    .serrTake, .serrRetAddr, .serrSyndrome, .implicitSyncSyndromeBit,
    .serrPending, .syncEventDone, .syncBusy
  );

  initial begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end

  // ==================================================================
  // helpers
  function automatic logic [31:0] rec(logic [2:0] s, logic [20:0] d);
    return {1'h1, 7'h0, s, d};
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samplesChecked++;
    if (g !== e) begin
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
      errCount++;
    end
  endtask

  task automatic ahb(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    htrans <= `ESU_HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge clock); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'h1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(a, 1'h1, d, q);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    ahb(a, 1'h0, 32'h0, q);
    chk(q, e);
  endtask

  // flags are {silent, level source, system irq, not consumed}
  task automatic err(input logic [2:0] s, input logic [20:0] d,
                     input logic [3:0] f);
    errValid <= 1'h1;
    errState <= s;
    errDetail <= d;
    {errSilent, errLevelSrc, errRasIrq, errNotConsumed} <= f;
    @(posedge clock);
    errValid <= 1'h0;
    @(posedge clock);
  endtask

  task automatic pulse(input int k, input logic [31:0] a);
    eventAddr <= a;
    errorBarrierInstr <= (k == 0);
    exceptionEntry <= (k == 1);
    exceptionReturn <= (k == 2);
    @(posedge clock);
    {errorBarrierInstr, exceptionEntry, exceptionReturn} <= 3'h0;
  endtask

  // upper bound only: flags are collected over the whole span
  task automatic watch(input int n);
    took = 1'h0;
    done = 1'h0;
    repeat (n) begin
      @(posedge clock);
      if (serrTake === 1'h1) took = 1'h1;
      if (syncEventDone === 1'h1) done = 1'h1;
    end
  endtask

  // ==================================================================
  // scenarios
  task automatic t_reset;
    rchk(CT, {30'h0, `ESU_CTRL_RST});
    rchk(DR, 32'h0);
    rchk(TS, 32'h0);
    wr(ST, 32'hffff_ffff);
    rchk(ST, 32'h0);
    wr(8'h40, 32'hffff_ffff);
    rchk(8'h40, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    chk({31'h0, syncBusy}, 32'h0);
  endtask

  task automatic t_defer;
    err(esu_pkg::ESU_RECOV, 21'h0a5a5a, 4'h0);
    rchk(ST, 32'h1);
    pulse(0, 32'h200);
    watch(12);
    chk({30'h0, took, done}, 32'h1);
    rchk(DR, rec(esu_pkg::ESU_RECOV, 21'h0a5a5a));
    rchk(ST, 32'h0);
    pulse(0, 32'h204);
    watch(12);
    rchk(DR, rec(esu_pkg::ESU_RECOV, 21'h0a5a5a));
    wr(DR, 32'h0);
    rchk(DR, 32'h0);
  endtask

  task automatic t_unsync;
    err(esu_pkg::ESU_RECOV, 21'h000333, 4'b0100);
    rchk(ST, 32'h2);
    pulse(0, 32'h208);
    watch(12);
    rchk(DR, 32'h0);
    rchk(ST, 32'h2);
    err(esu_pkg::ESU_RECOV, 21'h000444, 4'b0010);
    err(esu_pkg::ESU_RECOV, 21'h000888, 4'b0001);
    rchk(ST, 32'h2);
    serrMasked <= 1'h0;
    watch(6);
    chk({31'h0, took}, 32'h1);
    chk(serrRetAddr, PC);
    chk({8'h0, serrSyndrome}, {8'h0, 3'h2, 21'h000333});
    serrMasked <= 1'h1;
    rchk(ST, 32'h0);
  endtask

  task automatic t_implicit;
    wr(CT, 32'h3);
    err(esu_pkg::ESU_UNREC, 21'h001111, 4'h0);
    pulse(1, 32'h300);
    watch(12);
    chk({30'h0, took, done}, 32'h1);
    rchk(DR, 32'h0);
    rchk(ST, 32'h1);
    pulse(2, 32'h304);
    watch(12);
    chk({30'h0, took, done}, 32'h1);
    rchk(DR, 32'h0);
    wr(CT, 32'h2);
    pulse(1, 32'h300);
    watch(10);
    chk({31'h0, done}, 32'h0);
    pulse(0, 32'h308);
    watch(12);
    rchk(DR, rec(esu_pkg::ESU_UNREC, 21'h001111));
    wr(DR, 32'h0);
  endtask

  // error lands while the barrier drains, unmasked when it resolves
  task automatic t_take;
    errOutstanding <= 1'h1;
    pulse(0, 32'h400);
    err(esu_pkg::ESU_RECOV, 21'h000055, 4'h0);
    chk({31'h0, syncBusy}, 32'h1);
    rchk(ST, 32'h5);
    serrMasked <= 1'h0;
    errOutstanding <= 1'h0;
    watch(12);
    chk({30'h0, took, done}, 32'h3);
    chk(serrRetAddr, 32'h400);
    chk({8'h0, serrSyndrome}, {8'h0, 3'h2, 21'h000055});
    chk({31'h0, implicitSyncSyndromeBit}, 32'h0);
    serrMasked <= 1'h1;
    rchk(DR, 32'h0);
    rchk(RA, 32'h400);
  endtask

  task automatic t_prio;
    wr(CT, 32'h0);
    otherExcReq <= 1'h1;
    err(esu_pkg::ESU_RESTART, 21'h000777, 4'h0);
    serrMasked <= 1'h0;
    watch(6);
    chk({30'h0, took, serrPending}, 32'h1);
    wr(CT, 32'h2);
    rchk(ST, 32'h0);
    rchk(TS, {8'h0, 3'h1, 21'h000777});
    rchk(RA, PC);
    otherExcReq <= 1'h0;
    serrMasked <= 1'h1;
  endtask

  task automatic t_merge;
    err(esu_pkg::ESU_RECOV, 21'h000100, 4'h0);
    err(esu_pkg::ESU_UNREC, 21'h000011, 4'h0);
    pulse(0, 32'h500);
    watch(12);
    rchk(DR, rec(esu_pkg::ESU_UNREC, 21'h000111));
    wr(DR, 32'h0);
    err(esu_pkg::ESU_RESTART, 21'h000f00, 4'b1000);
    serrMasked <= 1'h0;
    watch(6);
    chk({31'h0, took}, 32'h1);
    chk({8'h0, serrSyndrome}, {8'h0, 3'h4, 21'h000f00});
    serrMasked <= 1'h1;
    // impdef error marked synchronizable dominates the merge
    errSyncHint <= 1'h1;
    err(esu_pkg::ESU_IMPDEF, 21'h000002, 4'h0);
    errSyncHint <= 1'h0;
    err(esu_pkg::ESU_RECOV, 21'h000001, 4'h0);
    pulse(0, 32'h504);
    watch(12);
    rchk(DR, rec(esu_pkg::ESU_IMPDEF, 21'h000003));
    wr(DR, 32'h0);
  endtask

  // ==================================================================
  // run control
  task automatic close_out;
    if (errCount == 0 && samplesChecked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // the whole sequence needs well under 1500 cycles
  initial begin
    #100000;
    errCount++;
    close_out;
  end

  initial begin
    {nrst, hsel, hwrite, errorBarrierInstr, exceptionEntry} = 5'h0;
    {exceptionReturn, otherExcReq, errOutstanding, errValid} = 4'h0;
    {errSyncHint, errSilent, errLevelSrc, errRasIrq} = 4'h0;
    errNotConsumed = 1'h0;
    serrMasked = 1'h1;
    {haddr, hwdata, eventAddr} = 96'h0;
    curPc = PC;
    htrans = 2'h0;
    hsize = 3'h2;
    errState = 3'h0;
    errDetail = '0;
    errCount = 0;
    samplesChecked = 0;
    repeat (2) @(posedge clock);
    nrst <= 1'h1;
    repeat (2) @(posedge clock);
    t_reset;
    t_defer;
    t_unsync;
    t_implicit;
    t_take;
    t_prio;
    t_merge;
    close_out;
  end
endmodule

`default_nettype wire
